// file: bvhq_pkg.sv
// Package of constants and types for the ray query front end.
// Summary of operation
// - Return ordering setting is ignored; results always return in order.
// - Full precision scattered form takes five independent register groups.
// - Half precision scattered form takes four groups, direction pairs shared.
// - Half precision mode ignores the fifth scattered address slot.
// - Base address is the low 40 bits, 256 byte aligned.
// - An 8 bit unsigned field gives box growth in ulps.
// - Box results are sorted only when bit 63 is set.
// - Node accesses are bounds checked against 42 bit count minus one.
// - Bit 119 enables node pointer flag features; clear ignores them.
// - Bit 120 selects triangle result layout: id/hit or barycentrics.
// - Two bit cache policy: normal, load only, reserved, bypass all.
// - Bit 123 allows assuming pages of at least 64kB.
// - Box nodes return four child pointers, sorted when bit 63 is set; triangles return hit data.
// - Half precision only for direction, low half, inverse in high half.
// - Wide pointer variant takes a two register node pointer.
package bvhq_pkg;
    localparam int BVHQ_BASE_LSB = 0;
    localparam int BVHQ_BASE_W = 40;
    localparam int BVHQ_ALIGN_BITS = 8;
    localparam int BVHQ_GROW_LSB = 55;
    localparam int BVHQ_GROW_W = 8;
    localparam int BVHQ_SORT_BIT = 63;
    localparam int BVHQ_SIZE_LSB = 64;
    localparam int BVHQ_SIZE_W = 42;
    localparam int BVHQ_PFLAG_BIT = 119;
    localparam int BVHQ_TRIMODE_BIT = 120;
    localparam int BVHQ_LLC_LSB = 121;
    localparam int BVHQ_BIGPG_BIT = 123;
    localparam int BVHQ_TYPE_LSB = 124;
    localparam logic [3:0] BVHQ_TYPE_CODE = 4'h8;
    localparam logic [3:0] BVHQ_MASK_ALL = 4'hF;
    localparam logic [2:0] BVHQ_DIM_1D = 3'h0;
    localparam logic [1:0] BVHQ_LLC_NORMAL = 2'h0;
    localparam logic [1:0] BVHQ_LLC_LOAD = 2'h1;
    localparam logic [1:0] BVHQ_LLC_RSVD = 2'h2;
    localparam logic [1:0] BVHQ_LLC_BYPASS = 2'h3;
    localparam logic [3:0] BVHQ_NUM_SLOTS = 4'h5;
    localparam logic [3:0] BVHQ_RAY_WORDS = 4'hC;
    // Error code bits reported with a rejected instruction.
    localparam int BVHQ_ERR_W = 4;
    localparam logic [3:0] BVHQ_ERR_FIELD = 4'h1;
    localparam logic [3:0] BVHQ_ERR_TYPE = 4'h2;
    localparam logic [3:0] BVHQ_ERR_BOUND = 4'h4;
    localparam logic [3:0] BVHQ_ERR_LLC = 4'h8;
    typedef enum logic [1:0] {BVHQ_ST_IDLE, BVHQ_ST_GATHER, BVHQ_ST_ISSUE}
        bvhq_state_e;
endpackage

// file: bvhq_ray_store.sv
`timescale 1ns/1ps
// Small register memory holding the twelve gathered ray words.
module bvhq_ray_store
    import bvhq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic [3:0] i_rd_addr,
    output logic [31:0] o_rd_data
);
    logic [31:0] mem [0:11];

    // Storage has no reset; words are always written before being read.
    always_ff @(posedge i_clk_sys) begin
        if (i_wr_en && i_wr_addr < BVHQ_RAY_WORDS) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read port.
    always_ff @(posedge i_clk_sys) begin
        o_rd_data <= (i_rd_addr < BVHQ_RAY_WORDS) ? mem[i_rd_addr] : 32'h0;
    end
endmodule

// file: bvhq_result_fmt.sv
`timescale 1ns/1ps
// Formats the four returned dwords for box and triangle nodes.
module bvhq_result_fmt
    import bvhq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic i_is_box,
    input wire logic i_tri_mode,
    input wire logic i_sort_en,
    input wire logic [31:0] i_child [4],
    input wire logic [31:0] i_child_t [4],
    input wire logic [31:0] i_t_num,
    input wire logic [31:0] i_t_denom,
    input wire logic [31:0] i_tri_id,
    input wire logic i_hit,
    input wire logic [31:0] i_i_num,
    input wire logic [31:0] i_j_num,
    output logic o_valid,
    output logic [31:0] o_dword [4]
);
    logic [1:0] rank [4];
    logic [31:0] sorted [4];
    logic [31:0] next_dword [4];

    // Rank each child by how many hit earlier; ties keep the lower index.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rank[i] = 2'h0;
            for (int j = 0; j < 4; j++) begin
                if ((i_child_t[j] < i_child_t[i]) ||
                    (i_child_t[j] == i_child_t[i] && j < i)) begin
                    rank[i] = rank[i] + 2'h1;
                end
            end
        end
        sorted = '{default: 32'h0};
        for (int i = 0; i < 4; i++) begin
            sorted[rank[i]] = i_child[i];
        end
    end

    // Pick the layout of the four result dwords.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            next_dword[k] = i_sort_en ? sorted[k] : i_child[k];
        end
        if (!i_is_box) begin
            next_dword[0] = i_t_num;
            next_dword[1] = i_t_denom;
            next_dword[2] = i_tri_mode ? i_i_num : i_tri_id;
            next_dword[3] = i_tri_mode ? i_j_num : {31'h0, i_hit};
        end
    end

    // Result registers drive the load return queue in issue order.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_dword <= '{default: 32'h0};
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_dword <= next_dword;
            end
        end
    end
endmodule

// file: bvhq_front_end.sv
`timescale 1ns/1ps
// Top of the ray query front end: field checks, gather and descriptor decode.
module bvhq_front_end
    import bvhq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Instruction issue.
    input wire logic i_issue_valid,
    input wire logic i_wide_pointer,
    input wire logic i_half_precision_addressing,
    input wire logic i_scattered_address_form,
    input wire logic [3:0] i_component_enable_mask,
    input wire logic i_half_precision_return,
    input wire logic i_narrow_descriptor_flag,
    input wire logic i_unnormalized_coords,
    input wire logic [2:0] i_texture_dimension,
    input wire logic i_lod_warning_enable,
    input wire logic i_extra_status_dword_enable,
    input wire logic [1:0] i_sampler_slot,
    input wire logic i_return_order,
    input wire logic [7:0] i_addr_base,
    input wire logic [7:0] i_addr_slot [5],
    input wire logic [127:0] i_descriptor,
    output logic o_issue_ready,
    // Register file read port.
    output logic o_rf_rd_en,
    output logic [7:0] o_rf_rd_addr,
    input wire logic [31:0] i_rf_rd_data,
    // Decoded request toward the intersection engine.
    output logic o_req_valid,
    output logic [BVHQ_ERR_W-1:0] o_req_error,
    output logic [63:0] o_node_pointer,
    output logic [47:0] o_base_byte_addr,
    output logic [7:0] o_box_grow_ulps,
    output logic o_sort_enable,
    output logic [41:0] o_node_limit,
    output logic o_pointer_flags_en,
    output logic o_tri_return_mode,
    output logic [1:0] o_llc_policy,
    output logic o_big_page,
    output logic o_ray_wr_en,
    output logic [3:0] o_ray_wr_idx,
    output logic [31:0] o_ray_wr_data,
    // Results from the engine and back to the shader.
    input wire logic i_res_valid,
    input wire logic i_res_is_box,
    input wire logic [31:0] i_child [4],
    input wire logic [31:0] i_child_t [4],
    input wire logic [31:0] i_t_num,
    input wire logic [31:0] i_t_denom,
    input wire logic [31:0] i_tri_id,
    input wire logic i_hit,
    input wire logic [31:0] i_i_num,
    input wire logic [31:0] i_j_num,
    input wire logic [3:0] i_ray_rd_idx,
    output logic [31:0] o_ray_rd_data,
    output logic o_ret_valid,
    output logic [31:0] o_ret_dword [4]
);
    logic rst_meta;
    logic rst_n;
    bvhq_state_e state;
    bvhq_state_e next_state;
    logic [3:0] word_idx;
    logic [3:0] words_total;
    logic rd_pend;
    logic [3:0] rd_pend_idx;
    logic wide_q;
    logic half_q;
    logic nsa_q;
    logic [7:0] base_q;
    logic [7:0] slot_q [5];
    logic [127:0] desc_q;
    logic [BVHQ_ERR_W-1:0] err_q;
    logic [31:0] ptr_lo;
    logic [31:0] ptr_hi;
    logic sort_en_q;
    logic tri_mode_q;

    // Count of address words: wide pointer adds one, half precision saves 3.
    function automatic logic [3:0] ray_words(input logic wide,
                                            input logic half);
        logic [3:0] n;
        n = half ? 4'h8 : 4'hB;
        if (wide) begin
            n = n + 4'h1;
        end
        return n;
    endfunction

    // Maps a word index to its scattered group and offset inside the group.
    function automatic logic [7:0] nsa_addr(input logic [7:0] slot [5],
                                            input logic wide,
                                            input logic [3:0] idx);
        logic [3:0] k;
        logic [7:0] a;
        k = wide ? idx - 4'h1 : idx;
        if (idx == 4'h0 || (wide && idx == 4'h1)) begin
            a = slot[0] + {4'h0, idx};
        end else if (k == 4'h1) begin
            a = slot[1];
        end else if (k < 4'h5) begin
            a = slot[2] + {4'h0, k - 4'h2};
        end else if (k < 4'h8) begin
            a = slot[3] + {4'h0, k - 4'h5};
        end else begin
            a = slot[4] + {4'h0, k - 4'h8};
        end
        return a;
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Operand field checks; the far side is expected to keep these right.
    wire field_bad = (i_component_enable_mask != BVHQ_MASK_ALL)
        || i_half_precision_return
        || !i_narrow_descriptor_flag
        || !i_unnormalized_coords
        || (i_texture_dimension != BVHQ_DIM_1D)
        || i_lod_warning_enable || i_extra_status_dword_enable
        || (i_sampler_slot != 2'h0);
    wire type_bad =
        i_descriptor[BVHQ_TYPE_LSB +: 4] != BVHQ_TYPE_CODE;
    wire llc_bad =
        i_descriptor[BVHQ_LLC_LSB +: 2] == BVHQ_LLC_RSVD;
    wire [BVHQ_ERR_W-1:0] issue_err =
        (field_bad ? BVHQ_ERR_FIELD : 4'h0) |
        (type_bad ? BVHQ_ERR_TYPE : 4'h0) |
        (llc_bad ? BVHQ_ERR_LLC : 4'h0);
    // The return order input is deliberately unused in any decode.
    wire order_ignored = i_return_order & 1'b0;

    // Half precision only ever reads slots 0 to 3; slot 4 is never used.
    wire [7:0] slot_sel [5] = '{slot_q[0], slot_q[1], slot_q[2], slot_q[3],
        half_q ? slot_q[3] : slot_q[4]};
    wire [7:0] gather_addr = nsa_q ? nsa_addr(slot_sel, wide_q, word_idx)
        : base_q + {4'h0, word_idx};
    wire gather_last = (word_idx == words_total - 4'h1);

    // Bounds check of the node index against the limit field.
    wire [63:0] node_ptr = wide_q ? {ptr_hi, ptr_lo} : {32'h0, ptr_lo};
    wire [41:0] node_limit = desc_q[BVHQ_SIZE_LSB +: BVHQ_SIZE_W];
    wire bound_bad = node_ptr[63:42] != 22'h0 ||
        node_ptr[41:0] > node_limit;

    // Next state of the gather sequencer.
    always_comb begin
        next_state = state;
        unique case (state)
            BVHQ_ST_IDLE: begin
                if (i_issue_valid && !order_ignored) begin
                    next_state = BVHQ_ST_GATHER;
                end
            end
            BVHQ_ST_GATHER: begin
                if (gather_last || err_q != 4'h0) begin
                    next_state = BVHQ_ST_ISSUE;
                end
            end
            BVHQ_ST_ISSUE: begin
                if (!rd_pend) begin
                    next_state = BVHQ_ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer state, captured instruction and gather bookkeeping.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= BVHQ_ST_IDLE;
            word_idx <= 4'h0;
            words_total <= 4'h0;
            wide_q <= 1'b0;
            half_q <= 1'b0;
            nsa_q <= 1'b0;
            base_q <= 8'h0;
            slot_q <= '{default: 8'h0};
            desc_q <= 128'h0;
            err_q <= 4'h0;
        end else begin
            state <= next_state;
            if (state == BVHQ_ST_IDLE && i_issue_valid) begin
                word_idx <= 4'h0;
                words_total <= ray_words(i_wide_pointer,
                    i_half_precision_addressing);
                wide_q <= i_wide_pointer;
                half_q <= i_half_precision_addressing;
                nsa_q <= i_scattered_address_form;
                base_q <= i_addr_base;
                slot_q <= i_addr_slot;
                desc_q <= i_descriptor;
                err_q <= issue_err;
            end else if (state == BVHQ_ST_GATHER) begin
                word_idx <= word_idx + 4'h1;
            end
        end
    end

    // Read data returns in the same cycle as the registered request; track it.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend <= 1'b0;
            rd_pend_idx <= 4'h0;
            ptr_lo <= 32'h0;
            ptr_hi <= 32'h0;
        end else begin
            rd_pend <= state == BVHQ_ST_GATHER && err_q == 4'h0;
            rd_pend_idx <= word_idx;
            if (rd_pend && rd_pend_idx == 4'h0) begin
                ptr_lo <= i_rf_rd_data;
            end
            if (rd_pend && wide_q && rd_pend_idx == 4'h1) begin
                ptr_hi <= i_rf_rd_data;
            end
        end
    end

    // Register file reads and ray word writes, all registered outputs.
    // Half precision words keep direction low and inverse high unchanged.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_rf_rd_en <= 1'b0;
            o_rf_rd_addr <= 8'h0;
            o_ray_wr_en <= 1'b0;
            o_ray_wr_idx <= 4'h0;
            o_ray_wr_data <= 32'h0;
        end else begin
            o_rf_rd_en <= state == BVHQ_ST_GATHER && err_q == 4'h0;
            o_rf_rd_addr <= gather_addr;
            o_ray_wr_en <= rd_pend;
            o_ray_wr_idx <= rd_pend_idx;
            o_ray_wr_data <= i_rf_rd_data;
        end
    end

    // Decoded descriptor and request strobe.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_issue_ready <= 1'b0;
            o_req_valid <= 1'b0;
            o_req_error <= 4'h0;
            o_node_pointer <= 64'h0;
            o_base_byte_addr <= 48'h0;
            o_box_grow_ulps <= 8'h0;
            o_sort_enable <= 1'b0;
            o_node_limit <= 42'h0;
            o_pointer_flags_en <= 1'b0;
            o_tri_return_mode <= 1'b0;
            o_llc_policy <= BVHQ_LLC_NORMAL;
            o_big_page <= 1'b0;
            sort_en_q <= 1'b0;
            tri_mode_q <= 1'b0;
        end else begin
            o_issue_ready <= next_state == BVHQ_ST_IDLE;
            o_req_valid <= state == BVHQ_ST_ISSUE && !rd_pend;
            if (state == BVHQ_ST_ISSUE && !rd_pend) begin
                o_req_error <= err_q | (bound_bad ? BVHQ_ERR_BOUND : 4'h0);
                o_node_pointer <= node_ptr;
                o_base_byte_addr <= {desc_q[BVHQ_BASE_LSB +: BVHQ_BASE_W],
                    {BVHQ_ALIGN_BITS{1'b0}}};
                o_box_grow_ulps <=
                    desc_q[BVHQ_GROW_LSB +: BVHQ_GROW_W];
                o_sort_enable <= desc_q[BVHQ_SORT_BIT];
                o_node_limit <= node_limit;
                o_pointer_flags_en <= desc_q[BVHQ_PFLAG_BIT];
                o_tri_return_mode <= desc_q[BVHQ_TRIMODE_BIT];
                o_llc_policy <= desc_q[BVHQ_LLC_LSB +: 2];
                o_big_page <= desc_q[BVHQ_BIGPG_BIT];
                sort_en_q <= desc_q[BVHQ_SORT_BIT];
                tri_mode_q <= desc_q[BVHQ_TRIMODE_BIT];
            end
        end
    end

    // Ray word storage, read by the intersection engine.
    bvhq_ray_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_wr_en(o_ray_wr_en),
        .i_wr_addr(o_ray_wr_idx),
        .i_wr_data(o_ray_wr_data),
        .i_rd_addr(i_ray_rd_idx),
        .o_rd_data(o_ray_rd_data)
    );

    // Result formatting into the in-order return path.
    bvhq_result_fmt u_fmt (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_valid(i_res_valid),
        .i_is_box(i_res_is_box),
        .i_tri_mode(tri_mode_q),
        .i_sort_en(sort_en_q),
        .i_child(i_child),
        .i_child_t(i_child_t),
        .i_t_num(i_t_num),
        .i_t_denom(i_t_denom),
        .i_tri_id(i_tri_id),
        .i_hit(i_hit),
        .i_i_num(i_i_num),
        .i_j_num(i_j_num),
        .o_valid(o_ret_valid),
        .o_dword(o_ret_dword)
    );
endmodule

// file: bvhq_props.sv
// Concurrent checks on the ports of the ray query front end.
`timescale 1ns/1ps
module bvhq_props
    import bvhq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [3:0] i_component_enable_mask,
    input wire logic [127:0] i_descriptor,
    input wire logic i_res_valid,
    input wire logic o_issue_ready,
    input wire logic o_rf_rd_en,
    input wire logic o_req_valid,
    input wire logic [BVHQ_ERR_W-1:0] o_req_error,
    input wire logic [47:0] o_base_byte_addr,
    input wire logic [7:0] o_box_grow_ulps,
    input wire logic o_sort_enable,
    input wire logic [41:0] o_node_limit,
    input wire logic o_pointer_flags_en,
    input wire logic o_tri_return_mode,
    input wire logic [1:0] o_llc_policy,
    input wire logic o_big_page,
    input wire logic o_ret_valid
);
    // Decoded fields are compared with the descriptor, held by the bench.
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_base_aligned: assert property (o_req_valid |->
        o_base_byte_addr == {i_descriptor[39:0], 8'h00})
        else $error("base address not taken from low bits");
    a_grow_sort: assert property (o_req_valid |->
        o_box_grow_ulps == i_descriptor[62:55] &&
        o_sort_enable == i_descriptor[63]) else $error("grow or sort wrong");
    a_node_limit: assert property (o_req_valid |->
        o_node_limit == i_descriptor[105:64]) else $error("node limit wrong");
    a_pflag_tri: assert property (o_req_valid |->
        o_pointer_flags_en == i_descriptor[119] &&
        o_tri_return_mode == i_descriptor[120]) else $error("flag bit wrong");
    a_llc_page: assert property (o_req_valid |->
        o_llc_policy == i_descriptor[122:121] &&
        o_big_page == i_descriptor[123]) else $error("llc or page wrong");
    a_type_err: assert property (o_req_valid |->
        o_req_error[1] == (i_descriptor[127:124] != 4'h8))
        else $error("type error flag wrong");
    a_field_err: assert property (o_req_valid &&
        i_component_enable_mask != 4'hF |-> o_req_error[0])
        else $error("mask violation not flagged");
    a_ret_latency: assert property (i_res_valid |=> o_ret_valid)
        else $error("result not returned next cycle");
    a_ret_quiet: assert property (!i_res_valid |=> !o_ret_valid)
        else $error("result returned without cause");
    a_read_busy: assert property (o_rf_rd_en |-> !o_issue_ready)
        else $error("ready while gathering");
    a_req_pulse: assert property (o_req_valid |=> !o_req_valid)
        else $error("request pulse too long");
    c_req_clean: cover property (o_req_valid && !o_req_error[0]);
    c_req_field: cover property (o_req_valid && o_req_error[0]);
    c_ret: cover property (o_ret_valid);
endmodule

bind bvhq_front_end bvhq_props u_props (.*);

// file: bvhq_rf_model.sv
// Behavioural vector register file answering gather reads.
`timescale 1ns/1ps
module bvhq_rf_model (
    input wire logic i_clk_sys,
    input wire logic i_rd_en,
    input wire logic [7:0] i_rd_addr,
    output logic [31:0] o_rd_data
);
    logic [31:0] idle = 32'h0;
    // A read is answered in its own cycle; the word encodes its address.
    // Between reads the data toggles, so a late sample shows up.
    always @(posedge i_clk_sys) idle <= ~idle;
    assign o_rd_data = i_rd_en ? {i_rd_addr, 8'hC3, ~i_rd_addr, 8'h5A}
        : idle;
endmodule

// file: bvhq_front_end_tb_top.sv
// Self-checking bench for the ray query front end.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module bvhq_front_end_tb_top
    import bvhq_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst_n, i_issue_valid, i_wide_pointer, i_half_precision_addressing;
    logic i_scattered_address_form, i_half_precision_return, i_return_order;
    logic i_narrow_descriptor_flag, i_unnormalized_coords, i_lod_warning_enable;
    logic i_extra_status_dword_enable, i_res_valid, i_res_is_box, i_hit;
    logic [3:0] i_component_enable_mask, i_ray_rd_idx, o_req_error;
    logic [2:0] i_texture_dimension;
    logic [1:0] i_sampler_slot, o_llc_policy;
    logic [7:0] i_addr_base, o_rf_rd_addr, o_box_grow_ulps;
    logic [7:0] i_addr_slot [5];
    logic [127:0] i_descriptor;
    logic [31:0] i_rf_rd_data, i_t_num, i_t_denom, i_tri_id, i_i_num, i_j_num;
    logic [31:0] o_ray_rd_data;
    logic [31:0] i_child [4];
    logic [31:0] i_child_t [4];
    logic [31:0] o_ret_dword [4];
    logic o_issue_ready, o_rf_rd_en, o_req_valid, o_sort_enable, o_big_page;
    logic o_pointer_flags_en, o_tri_return_mode, o_ret_valid;
    logic [63:0] o_node_pointer;
    logic [47:0] o_base_byte_addr;
    logic [41:0] o_node_limit;
    int fail_count = 0;
    int num_checks = 0;
    logic [7:0] got_q [$];
    logic [7:0] exp_q [$];

    // A 40 ns period gives the 25 MHz core clock.
    always #20 i_clk_sys = ~i_clk_sys;

    bvhq_front_end u_dut (.*, .o_ray_wr_en(), .o_ray_wr_idx(),
        .o_ray_wr_data());

    bvhq_rf_model u_rf (.i_clk_sys, .i_rd_en(o_rf_rd_en),
        .i_rd_addr(o_rf_rd_addr), .o_rd_data(i_rf_rd_data));

    // Word the register file returns for a given register number.
    function automatic logic [31:0] rf_word(input logic [7:0] a);
        return {a, 8'hC3, ~a, 8'h5A};
    endfunction

    // Descriptor with fixed base, growth and size; f is big, tri, pf, sort.
    function automatic logic [127:0] desc(input logic [1:0] llc,
        input logic [3:0] ty, input logic [3:0] f);
        return {ty, f[3], llc, f[2], f[1], 13'h0, 42'h2AB_CDEF_0123,
            f[0], 8'hA7, 15'h0, 40'h12_3456_789A};
    endfunction

    // Legal settings for every checked instruction field.
    task automatic legal();
        i_component_enable_mask = BVHQ_MASK_ALL;
        i_half_precision_return = 1'b0;
        i_narrow_descriptor_flag = 1'b1;
        i_unnormalized_coords = 1'b1;
        i_texture_dimension = BVHQ_DIM_1D;
        i_lod_warning_enable = 1'b0;
        i_extra_status_dword_enable = 1'b0;
        i_sampler_slot = 2'h0;
    endtask

    // Issues one instruction and checks the gather reads and stored words.
    task automatic run_op(input logic w, input logic h, input logic s,
        input logic [3:0] eerr);
        int k;
        exp_q.delete();
        got_q.delete();
        i_wide_pointer = w;
        i_half_precision_addressing = h;
        i_scattered_address_form = s;
        if (!s) begin
            for (k = 0; k < (h ? 8 : 11) + int'(w); k++)
                exp_q.push_back(i_addr_base + 8'(k));
        end else begin
            for (k = 0; k < 1 + int'(w); k++)
                exp_q.push_back(i_addr_slot[0] + 8'(k));
            exp_q.push_back(i_addr_slot[1]);
            for (k = 0; k < (h ? 6 : 9); k++)
                exp_q.push_back(i_addr_slot[2 + k / 3] + 8'(k % 3));
        end
        if (eerr != 4'h0)
            exp_q.delete();
        k = 0;
        while (o_issue_ready !== 1'b1 && k < 50) begin
            @(negedge i_clk_sys);
            k++;
        end
        i_issue_valid = 1'b1;
        @(negedge i_clk_sys);
        i_issue_valid = 1'b0;
        k = 0;
        while (o_req_valid !== 1'b1 && k < 60) begin
            if (o_rf_rd_en === 1'b1)
                got_q.push_back(o_rf_rd_addr);
            @(negedge i_clk_sys);
            k++;
        end
        `CHK(o_req_valid, 1'b1)
        `CHK(o_req_error, eerr | (w ? BVHQ_ERR_BOUND : 4'h0))
        `CHK(got_q.size(), exp_q.size())
        foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
        if (exp_q.size() > 0) begin
            `CHK(o_node_pointer[31:0], rf_word(exp_q[0]))
            if (w) `CHK(o_node_pointer[63:32], rf_word(exp_q[1]))
            foreach (exp_q[i]) begin
                i_ray_rd_idx = 4'(i);
                @(negedge i_clk_sys);
                `CHK(o_ray_rd_data, rf_word(exp_q[i]))
            end
        end
        @(negedge i_clk_sys);
    endtask

    // Offers one result from the engine and checks the returned dwords.
    task automatic ret(input logic box, input logic [31:0] e [4]);
        i_res_valid = 1'b1;
        i_res_is_box = box;
        @(negedge i_clk_sys);
        i_res_valid = 1'b0;
        `CHK(o_ret_valid, 1'b1)
        for (int j = 0; j < 4; j++) `CHK(o_ret_dword[j], e[j])
        @(negedge i_clk_sys);
        `CHK(o_ret_valid, 1'b0)
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence: reset, gather forms, field refusals, codes, results.
    initial begin
        i_rst_n = 1'b0;
        i_issue_valid = 1'b0;
        i_return_order = 1'b0;
        i_addr_base = 8'h40;
        i_addr_slot = '{8'h10, 8'h20, 8'h30, 8'h50, 8'h70};
        i_descriptor = desc(2'h0, BVHQ_TYPE_CODE, 4'h0);
        i_res_valid = 1'b0;
        i_res_is_box = 1'b0;
        i_child = '{32'hC0, 32'hC1, 32'hC2, 32'hC3};
        i_child_t = '{32'h30, 32'h10, 32'h20, 32'h10};
        i_t_num = 32'h3F80_0000;
        i_t_denom = 32'h4000_0000;
        i_tri_id = 32'h77;
        i_hit = 1'b1;
        i_i_num = 32'h3E00_0000;
        i_j_num = 32'h3E80_0000;
        i_ray_rd_idx = 4'h0;
        i_wide_pointer = 1'b0;
        i_half_precision_addressing = 1'b0;
        i_scattered_address_form = 1'b0;
        legal();
        repeat (6) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        // Every pointer width, precision and address form; order flipped.
        for (int t = 0; t < 8; t++) begin
            i_return_order = t[0];
            i_descriptor = desc({t[1], t[1] | t[0]}, BVHQ_TYPE_CODE,
                {t[0], t[2:0]});
            run_op(t[2], t[1], t[0], 4'h0);
        end
        $display("test gather done");
        // One illegal field at a time; the request must carry the flag.
        for (int j = 0; j < 8; j++) begin
            legal();
            case (j)
                0: i_component_enable_mask = 4'h7;
                1: i_half_precision_return = 1'b1;
                2: i_narrow_descriptor_flag = 1'b0;
                3: i_unnormalized_coords = 1'b0;
                4: i_texture_dimension = 3'h1;
                5: i_lod_warning_enable = 1'b1;
                6: i_extra_status_dword_enable = 1'b1;
                default: i_sampler_slot = 2'h1;
            endcase
            run_op(1'b0, 1'b0, 1'b0, BVHQ_ERR_FIELD);
        end
        legal();
        $display("test fields done");
        i_descriptor = desc(BVHQ_LLC_RSVD, BVHQ_TYPE_CODE, 4'h0);
        run_op(1'b0, 1'b1, 1'b1, BVHQ_ERR_LLC);
        i_descriptor = desc(BVHQ_LLC_NORMAL, 4'h4, 4'h0);
        run_op(1'b0, 1'b0, 1'b1, BVHQ_ERR_TYPE);
        $display("test codes done");
        // Sorted boxes with a tie, then identifier return for triangles.
        i_descriptor = desc(BVHQ_LLC_NORMAL, BVHQ_TYPE_CODE, 4'h1);
        run_op(1'b0, 1'b0, 1'b0, 4'h0);
        ret(1'b1, '{32'hC1, 32'hC3, 32'hC2, 32'hC0});
        ret(1'b0, '{i_t_num, i_t_denom, i_tri_id, 32'h1});
        i_descriptor = desc(BVHQ_LLC_BYPASS, BVHQ_TYPE_CODE, 4'h4);
        run_op(1'b1, 1'b0, 1'b0, 4'h0);
        ret(1'b1, '{32'hC0, 32'hC1, 32'hC2, 32'hC3});
        ret(1'b0, '{i_t_num, i_t_denom, i_i_num, i_j_num});
        $display("test results done");
        tally_and_finish();
    end

    // The tests need well under 2000 cycles; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        fail_count++;
        tally_and_finish();
    end
endmodule
